// File: verilog/lps_consts.svh
/*
 * Named constants of the protection sequencer: timing, register map and fields.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LPS_CLK_MHZ 40
`define LPS_OVP_BLANK_NS 2000
`define LPS_OVP_WIN_NS 500
// Blanking is a least time: round up; window is a longest time: round down
`define LPS_OVP_BLANK_CYC ((`LPS_OVP_BLANK_NS * `LPS_CLK_MHZ + 999) / 1000)
`define LPS_OVP_WIN_CYC ((`LPS_OVP_WIN_NS * `LPS_CLK_MHZ) / 1000)
`define LPS_OVP_TRIPS 4

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define LPS_ADDR_CTRL 12'h000
`define LPS_ADDR_STATUS 12'h004
`define LPS_ADDR_EVENT 12'h008

// Control fields and reset value
`define LPS_CTRL_OVP_EN 0
`define LPS_CTRL_HOLD 1
`define LPS_CTRL_RST 2'h1

// Status fields
`define LPS_STAT_STATE_LSB 0
`define LPS_STAT_CNT_LSB 8
`define LPS_STAT_HV 12

// Sticky event bits
`define LPS_EV_LATCH 0
`define LPS_EV_OVP 1
`define LPS_EV_OVL 2
`define LPS_EV_AUTO 3
`define LPS_EV_W 4

`endif

// File: verilog/lps_pkg.sv
/*
 * Types of the protection sequencer.
 * Assumes nothing of its surroundings.
 */
package lps_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_OFF     = 8'h01,
    ST_SOFT    = 8'h02,
    ST_RUN     = 8'h04,
    ST_OVL     = 8'h08,
    ST_AUTO    = 8'h10,
    ST_OVP     = 8'h20,
    ST_LATCH   = 8'h40,
    ST_RELEASE = 8'h80
  } lps_state_e;

endpackage

// File: verilog/lps_ovp_window.sv
/*
 * Overvoltage window sampler: opens a short window after each switch turn-off
 * and counts consecutive switching cycles in which the comparator tripped.
 * Assumes the gate and comparator inputs are synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`include "lps_consts.svh"

module lps_ovp_window #(
  parameter int TMR_W = 8,
  parameter int CNT_W = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic gate_i,
  input wire logic ovp_cmp_i,
  output logic [CNT_W-1:0] count_o,
  output logic trip_o
);

  localparam logic [TMR_W-1:0] BLANK = TMR_W'(`LPS_OVP_BLANK_CYC);
  localparam logic [TMR_W-1:0] WEND = TMR_W'(`LPS_OVP_BLANK_CYC + `LPS_OVP_WIN_CYC);
  localparam logic [CNT_W-1:0] TRIPS = CNT_W'(`LPS_OVP_TRIPS);

  logic gate_q;
  logic run_q;
  logic hit_q;
  logic [TMR_W-1:0] tmr_q;
  logic [CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------------------
  wire turn_off = gate_q && !gate_i;
  wire window = run_q && !gate_i && (tmr_q >= BLANK) && (tmr_q < WEND);
  wire close = window && (tmr_q == WEND - TMR_W'(1));
  wire hit = hit_q || (window && ovp_cmp_i);
  wire [CNT_W-1:0] cnt_next = (cnt_q == TRIPS) ? cnt_q : cnt_q + CNT_W'(1);

  // Off-time timer and in-window trip memory
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_q <= 1'b0;
      run_q <= 1'b0;
      hit_q <= 1'b0;
      tmr_q <= '0;
    end else if (ce_i) begin
      gate_q <= gate_i;
      run_q <= turn_off || (run_q && !gate_i && (tmr_q < WEND));
      tmr_q <= turn_off ? '0 : (run_q ? tmr_q + TMR_W'(1) : tmr_q);
      hit_q <= !turn_off && hit;
    end
  end

  // Consecutive trip counter, cleared by a clean cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (!enable_i) begin
        cnt_q <= '0;
      end else if (close) begin
        cnt_q <= hit ? cnt_next : '0;
      end
    end
  end

  assign count_o = cnt_q;
  assign trip_o = enable_i && (cnt_q == TRIPS);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_window_place: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    window |-> (tmr_q >= BLANK) && (tmr_q < WEND) && !gate_i
  ) else $error("overvoltage window outside its slot");

  a_count_clear: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && close && !hit |=> cnt_q == '0
  ) else $error("trip counter not cleared by clean cycle");

  a_trip_fourth: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && enable_i && close && hit && (cnt_q == TRIPS - CNT_W'(1)) ##1 enable_i |-> trip_o
  ) else $error("fourth consecutive trip did not stop");

  a_window_open: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && turn_off ##1 (ce_i && !gate_i) [*8] |-> !window
  ) else $error("window opened during blanking");

  c_ovp_trip: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(trip_o));

endmodule // lps_ovp_window

// File: verilog/lps_protect_top.sv
/*
 * Protection sequencer: latched disable, soft-start with delayed overload
 * shutdown, overvoltage shutdown, and an APB register slave.
 * Assumes comparator decisions arrive as synchronous bits on sys_clk_i and
 * that the analog side turns the control outputs into currents and switches.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
// Notes on behaviour
// - Disable comparator high latches device off immediately
// - Latch clears only on supply undervoltage
// - Latched: start-up generator cycles supply hysteresis
// - Mains low while latched: generator off until restart
// - Start-up charges soft-start with first current
// - Control monitors disabled until soft-start at 2 V
// - Control saturation: drop clamp, quarter charge current
// - 5 V auto-disables; 5 V plus 2 Vbe latches
// - Overload gone: stop second current, back to clamp
// - Gate stop never relies on grounded soft-start
// - Off-time aux sense above 5 V shuts down
// - Overvoltage sources feedforward current; high feedforward latches
// - No feedforward latch: restart below 5 V supply
// - Overvoltage sampled in window after turn-off
// - Stop after four consecutive overvoltage trips
// - Clean cycle clears overvoltage trip counter
// - Mains low while latched: latch holds until supply falls below restart
`timescale 1ns/1ps
`include "lps_consts.svh"

module lps_protect_top #(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Comparator decisions
  input wire logic shutdown_latch_input_i,
  input wire logic vcc_uvlo_i,
  input wire logic vcc_above_startup_i,
  input wire logic vcc_below_hyst_i,
  input wire logic vcc_below_restart_i,
  input wire logic vcc_below_5v_i,
  input wire logic mains_ok_sense_low_i,
  input wire logic ss_at_clamp_i,
  input wire logic ss_at_5v_i,
  input wire logic ss_at_latch_i,
  input wire logic comp_saturated_i,
  input wire logic aux_winding_sense_ovp_i,
  input wire logic feedforward_pin_at_latch_i,
  input wire logic pwm_gate_i,
  // Control outputs
  output logic gate_drv_o,
  output logic softstart_charge_current_o,
  output logic ss_clamp_en_o,
  output logic overload_charge_current_o,
  output logic ss_discharge_o,
  output logic hv_gen_on_o,
  output logic feedforward_pin_source_o,
  output logic low_power_o,
  output logic comp_monitor_en_o,
  output logic latched_o
);

  // ----------------------------------------------------------------------------
  // Comparator sampling
  // ----------------------------------------------------------------------------
  localparam int NCMP = 14;

  logic [NCMP-1:0] cmp_q;

  // One clocked sample of every analog decision
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_q <= '0;
    end else if (ce_i) begin
      cmp_q <= {shutdown_latch_input_i, vcc_uvlo_i, vcc_above_startup_i,
                vcc_below_hyst_i, vcc_below_restart_i, vcc_below_5v_i,
                mains_ok_sense_low_i, ss_at_clamp_i, ss_at_5v_i, ss_at_latch_i,
                comp_saturated_i, aux_winding_sense_ovp_i,
                feedforward_pin_at_latch_i, pwm_gate_i};
    end
  end

  wire dis_c = cmp_q[13];
  wire uvlo_c = cmp_q[12];
  wire vcc_on_c = cmp_q[11];
  wire vcc_hyst_c = cmp_q[10];
  wire vcc_restart_c = cmp_q[9];
  wire vcc_5v_c = cmp_q[8];
  wire mains_low_c = cmp_q[7];
  wire ss_clamp_c = cmp_q[6];
  wire ss_5v_c = cmp_q[5];
  wire ss_latch_c = cmp_q[4];
  wire comp_sat_c = cmp_q[3];
  wire ovp_cmp_c = cmp_q[2];
  wire ff_latch_c = cmp_q[1];
  wire pwm_c = cmp_q[0];

  // ----------------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------------
  lps_pkg::lps_state_e state_q;
  lps_pkg::lps_state_e state_d;
  logic [1:0] ctrl_q;
  logic [`LPS_EV_W-1:0] ev_q;
  logic hv_on_q;
  logic gate_q;
  logic rd_arm_q;
  logic [31:0] prdata_q;
  logic [CNT_W-1:0] ovp_count;
  logic ovp_trip;

  wire ovp_en = ctrl_q[`LPS_CTRL_OVP_EN];
  wire sw_hold = ctrl_q[`LPS_CTRL_HOLD];
  wire st_off = (state_q == lps_pkg::ST_OFF);
  wire st_soft = (state_q == lps_pkg::ST_SOFT);
  wire st_run = (state_q == lps_pkg::ST_RUN);
  wire st_ovl = (state_q == lps_pkg::ST_OVL);
  wire st_auto = (state_q == lps_pkg::ST_AUTO);
  wire st_ovp = (state_q == lps_pkg::ST_OVP);
  wire st_latch = (state_q == lps_pkg::ST_LATCH);
  wire st_rel = (state_q == lps_pkg::ST_RELEASE);
  wire switching = st_soft || st_run || st_ovl;

  // ----------------------------------------------------------------------------
  // Overvoltage window and counter
  // ----------------------------------------------------------------------------
  lps_ovp_window #(
    .TMR_W(8),
    .CNT_W(CNT_W)
  ) u_ovp (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .enable_i(ovp_en && switching),
    .gate_i(gate_q),
    .ovp_cmp_i(ovp_cmp_c),
    .count_o(ovp_count),
    .trip_o(ovp_trip)
  );

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Next state: undervoltage first, then the disable latch, then per state
  always_comb begin
    state_d = state_q;
    if (uvlo_c) begin
      state_d = lps_pkg::ST_OFF;
    end else if (dis_c) begin
      state_d = lps_pkg::ST_LATCH;
    end else begin
      case (state_q)
        lps_pkg::ST_OFF: begin
          if (vcc_on_c && !sw_hold) begin
            state_d = lps_pkg::ST_SOFT;
          end
        end
        lps_pkg::ST_SOFT: begin
          if (ovp_trip) begin
            state_d = lps_pkg::ST_OVP;
          end else if (ss_clamp_c) begin
            state_d = lps_pkg::ST_RUN;
          end
        end
        lps_pkg::ST_RUN: begin
          if (ovp_trip) begin
            state_d = lps_pkg::ST_OVP;
          end else if (comp_sat_c) begin
            state_d = lps_pkg::ST_OVL;
          end
        end
        lps_pkg::ST_OVL: begin
          if (ovp_trip) begin
            state_d = lps_pkg::ST_OVP;
          end else if (ss_latch_c) begin
            state_d = lps_pkg::ST_LATCH;
          end else if (ss_5v_c) begin
            state_d = lps_pkg::ST_AUTO;
          end else if (!comp_sat_c) begin
            state_d = lps_pkg::ST_RUN;
          end
        end
        lps_pkg::ST_AUTO: begin
          if (ss_latch_c) begin
            state_d = lps_pkg::ST_LATCH;
          end
        end
        lps_pkg::ST_OVP: begin
          if (ff_latch_c) begin
            state_d = lps_pkg::ST_LATCH;
          end else if (vcc_5v_c) begin
            state_d = lps_pkg::ST_OFF;
          end
        end
        lps_pkg::ST_LATCH: begin
          if (mains_low_c) begin
            state_d = lps_pkg::ST_RELEASE;
          end
        end
        lps_pkg::ST_RELEASE: begin
          if (vcc_restart_c) begin
            state_d = lps_pkg::ST_OFF;
          end
        end
        default: begin
          state_d = lps_pkg::ST_OFF;
        end
      endcase
    end
  end

  // State, gate and latched-off supply hysteresis
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= lps_pkg::ST_OFF;
      gate_q <= 1'b0;
      hv_on_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      gate_q <= switching && pwm_c;
      hv_on_q <= st_latch && (vcc_hyst_c || (hv_on_q && !vcc_on_c));
    end
  end

  // ----------------------------------------------------------------------------
  // Control outputs decoded from state
  // ----------------------------------------------------------------------------
  assign gate_drv_o = gate_q;
  assign softstart_charge_current_o = st_soft || st_run;
  assign ss_clamp_en_o = st_soft || st_run;
  assign overload_charge_current_o = st_ovl || st_auto;
  assign ss_discharge_o = st_off;
  assign hv_gen_on_o = (st_off && !vcc_on_c) || (st_latch && hv_on_q);
  assign feedforward_pin_source_o = st_ovp;
  assign low_power_o = st_latch || st_rel || st_auto || st_ovp;
  assign comp_monitor_en_o = st_run || st_ovl;
  assign latched_o = st_latch || st_rel;

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  wire sel_ctrl = (paddr_i == `LPS_ADDR_CTRL);
  wire sel_stat = (paddr_i == `LPS_ADDR_STATUS);
  wire sel_ev = (paddr_i == `LPS_ADDR_EVENT);
  wire unmapped = !(sel_ctrl || sel_stat || sel_ev);
  wire access = psel_i && penable_i && pready_o;
  wire wr_en = access && pwrite_i && ce_i;
  wire [31:0] status_w = {19'h0, hv_gen_on_o, 1'b0, ovp_count, state_q};
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_q} :
                       sel_stat ? status_w :
                       sel_ev ? {28'h0, ev_q} : 32'h0;

  // Reads answer once the data has been captured at a live edge
  assign pready_o = ce_i && (pwrite_i || rd_arm_q);
  assign pslverr_o = pready_o && psel_i && penable_i && unmapped;
  assign prdata_o = prdata_q;

  // Read capture
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_arm_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce_i) begin
      rd_arm_q <= psel_i && !pwrite_i && !access;
      prdata_q <= rd_mux;
    end
  end

  // Sticky events: set wins over a write-one clear
  wire [`LPS_EV_W-1:0] ev_set;
  assign ev_set[`LPS_EV_LATCH] = (state_d == lps_pkg::ST_LATCH) && !st_latch;
  assign ev_set[`LPS_EV_OVP] = (state_d == lps_pkg::ST_OVP) && !st_ovp;
  assign ev_set[`LPS_EV_OVL] = (state_d == lps_pkg::ST_OVL) && !st_ovl;
  assign ev_set[`LPS_EV_AUTO] = (state_d == lps_pkg::ST_AUTO) && !st_auto;
  wire [`LPS_EV_W-1:0] ev_clr = (wr_en && sel_ev) ? pwdata_i[`LPS_EV_W-1:0] : '0;

  // Control and event registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `LPS_CTRL_RST;
      ev_q <= '0;
    end else if (ce_i) begin
      if (wr_en && sel_ctrl) begin
        ctrl_q <= pwdata_i[1:0];
      end
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_disable_latch: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && dis_c && !uvlo_c |=> st_latch && low_power_o
  ) else $error("disable comparator did not latch off");

  a_latch_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    st_latch && !uvlo_c && !mains_low_c |=> st_latch
  ) else $error("latch left without undervoltage");

  a_hv_release: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && st_latch && mains_low_c && !uvlo_c && !dis_c |=> !hv_gen_on_o throughout
      (st_rel [*2])
  ) else $error("generator on after mains low while latched");

  a_monitor_off: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    st_soft |-> !comp_monitor_en_o && ss_clamp_en_o && softstart_charge_current_o
  ) else $error("control monitors active during soft-start");

  a_ovl_entry: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && st_run && comp_sat_c && !uvlo_c && !dis_c && !ovp_trip
      |=> overload_charge_current_o && !ss_clamp_en_o
  ) else $error("saturation did not start overload charge");

  a_auto_disable: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && st_ovl && ss_5v_c && !ss_latch_c && !uvlo_c && !dis_c && !ovp_trip |=> st_auto
  ) else $error("5 V on soft-start did not disable");

  a_ovl_return: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && st_ovl && !comp_sat_c && !ss_5v_c && !ss_latch_c && !uvlo_c && !dis_c && !ovp_trip
      |=> !overload_charge_current_o && ss_clamp_en_o
  ) else $error("overload end did not restore clamp");

  a_gate_stop: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && !switching |=> !gate_drv_o
  ) else $error("gate active outside switching states");

  a_ovp_shutdown: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && ovp_trip && st_run && !uvlo_c && !dis_c |=> feedforward_pin_source_o ##1 !gate_drv_o
  ) else $error("overvoltage did not shut down");

  a_ovp_restart: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ce_i && st_ovp && vcc_5v_c && !ff_latch_c && !uvlo_c && !dis_c |=> st_off
  ) else $error("no restart after overvoltage below 5 V");

  c_latched: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(st_latch));
  c_auto: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $rose(st_auto));
  c_ovl_back: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) st_ovl ##1 st_run);
  c_release: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) st_rel ##1 st_off);

endmodule // lps_protect_top

// File: verification/lps_analog_model.sv
/*
 * Far-side model: soft-start capacitor, feedforward pin and aux winding.
 * Assumes the sequencer's control outputs as inputs, all on one clock.
 */
`timescale 1ns/1ps
module lps_analog_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic charge_i,
  input wire logic clamp_i,
  input wire logic ovl_charge_i,
  input wire logic discharge_i,
  input wire logic ff_source_i,
  input wire logic gate_i,
  input wire logic latch_mode_i,
  input wire logic ovp_level_i,
  input wire logic spike_only_i,
  input wire logic ff_low_z_i,
  output logic ss_at_clamp_o,
  output logic ss_at_5v_o,
  output logic ss_at_latch_o,
  output logic aux_ovp_o,
  output logic ff_at_latch_o
);
  logic [7:0] ss_q;
  logic [7:0] ff_q;
  logic [7:0] off_q;
  logic [7:0] ss_top;
  // Without latch_mode_i, the diode to the reference keeps the capacitor below the latch level
  assign ss_top = latch_mode_i ? 8'hc8 : 8'h64;
  // Capacitor, feedforward node and off-time counter
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ss_q <= 8'h00;
      ff_q <= 8'h00;
      off_q <= 8'h00;
    end else begin
      if (discharge_i) ss_q <= 8'h00;
      else if (ovl_charge_i) ss_q <= (ss_q < ss_top) ? ss_q + 8'h01 : ss_q;
      else if (charge_i && clamp_i && ss_q < 8'h28) ss_q <= ss_q + 8'h01;
      else if (ss_q > 8'h28) ss_q <= ss_q - 8'h01;
      if (!ff_source_i) ff_q <= 8'h00;
      else if (!ff_low_z_i && ff_q < 8'h40) ff_q <= ff_q + 8'h01;
      off_q <= gate_i ? 8'h00 : ((off_q == 8'hff) ? off_q : off_q + 8'h01);
    end
  end
  // Comparator levels; a spike fades well before the sampling window
  assign ss_at_clamp_o = ss_q >= 8'h28;
  assign ss_at_5v_o = ss_q >= 8'h64;
  assign ss_at_latch_o = ss_q >= 8'h78;
  assign ff_at_latch_o = ff_q >= 8'h40;
  assign aux_ovp_o = ovp_level_i && !gate_i && (!spike_only_i || off_q < 8'h28);
endmodule // lps_analog_model

// File: verification/tb_latched_protection_softstart_ovp.sv
/*
 * Self-checking bench of the protection sequencer beside its analog model.
 * Assumes the design files and the model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_latched_protection_softstart_ovp;
  logic clk, rst_n, ce, psel, pen, pwr;
  logic [11:0] pa;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic prdy, perr, dis, uvlo, von, vhy, vrs, v5, mlo, sat, pwm;
  logic lmode, lvl, spk, lowz, scl, s5, slt, aux, ffl;
  logic gate, chg, clmp, ovl, dsc, hv, ffs, lp, mon, lat;
  logic [7:0] pc;
  int fails, compares;

  // ----------------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------------
  lps_protect_top u_lps_protect_top (
    .sys_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .shutdown_latch_input_i(dis), .vcc_uvlo_i(uvlo),
    .vcc_above_startup_i(von), .vcc_below_hyst_i(vhy), .vcc_below_restart_i(vrs),
    .vcc_below_5v_i(v5), .mains_ok_sense_low_i(mlo), .ss_at_clamp_i(scl),
    .ss_at_5v_i(s5), .ss_at_latch_i(slt), .comp_saturated_i(sat),
    .aux_winding_sense_ovp_i(aux), .feedforward_pin_at_latch_i(ffl), .pwm_gate_i(pwm),
    .gate_drv_o(gate), .softstart_charge_current_o(chg), .ss_clamp_en_o(clmp),
    .overload_charge_current_o(ovl), .ss_discharge_o(dsc), .hv_gen_on_o(hv),
    .feedforward_pin_source_o(ffs), .low_power_o(lp), .comp_monitor_en_o(mon),
    .latched_o(lat));
  lps_analog_model u_lps_analog_model (
    .sys_clk_i(clk), .reset_n_i(rst_n), .charge_i(chg), .clamp_i(clmp),
    .ovl_charge_i(ovl), .discharge_i(dsc), .ff_source_i(ffs), .gate_i(gate),
    .latch_mode_i(lmode), .ovp_level_i(lvl), .spike_only_i(spk), .ff_low_z_i(lowz),
    .ss_at_clamp_o(scl), .ss_at_5v_o(s5), .ss_at_latch_o(slt), .aux_ovp_o(aux),
    .ff_at_latch_o(ffl));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Switching pattern: 10 cycles on, 120 off
  always @(posedge clk) begin
    pc <= (pc == 8'h81) ? 8'h00 : pc + 8'h01;
    pwm <= pc < 8'h0a;
  end

  // One APB transfer; read data taken where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      fails++;
      test_done();
    end
  endtask
  // Poll the status word until the masked value shows up
  task automatic wst(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0, r, e);
      n++;
    end while ((r & m) !== v && n < 300);
    `CHK("status", v, r & m)
    if (n >= 300) test_done();
    @(negedge clk);
  endtask
  task automatic wsts(input lps_pkg::lps_state_e s);
    wst(32'hff, {24'h0, s});
  endtask
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values and an unmapped address
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    `CHK("discharge", 1'b1, dsc)
    `CHK("hv", 1'b1, hv)
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("ctrl", 32'h1, r)
    apb(1'b1, 12'h000, 32'h2, r, e);
    `CHK("ctrl wr err", 1'b0, e)
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("ctrl", 32'h2, r)
    apb(1'b1, 12'h000, 32'h1, r, e);
    apb(1'b1, 12'h0f0, 32'hffff_ffff, r, e);
    `CHK("wr err", 1'b1, e)
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    `CHK("rd err", 1'b1, e)
    `CHK("rd data", 32'h0, r)
  endtask
  // Start-up ramp up to the clamp
  task automatic boot();
    @(posedge clk);
    von <= 1'b1;
    wsts(lps_pkg::ST_SOFT);
    `CHK("charge", 1'b1, chg)
    `CHK("monitor", 1'b0, mon)
    wsts(lps_pkg::ST_RUN);
    `CHK("monitor", 1'b1, mon)
    @(posedge clk);
    von <= 1'b0;
  endtask
  // Undervoltage clears whatever is left
  task automatic clr();
    @(posedge clk);
    {sat, lvl, dis, lmode, lowz, uvlo} <= 6'h01;
    wsts(lps_pkg::ST_OFF);
    @(posedge clk);
    uvlo <= 1'b0;
  endtask
  // Overload: recovery, then auto-restart shutdown and its events
  task automatic t_ovl();
    logic [31:0] r;
    logic e;
    @(posedge clk);
    sat <= 1'b1;
    wsts(lps_pkg::ST_OVL);
    `CHK("ovl chg", 1'b1, ovl)
    `CHK("clamp", 1'b0, clmp)
    @(posedge clk);
    sat <= 1'b0;
    wsts(lps_pkg::ST_RUN);
    `CHK("ovl chg", 1'b0, ovl)
    @(posedge clk);
    sat <= 1'b1;
    wsts(lps_pkg::ST_AUTO);
    `CHK("gate", 1'b0, gate)
    apb(1'b0, 12'h008, 32'h0, r, e);
    `CHK("events", 32'hc, r)
    apb(1'b1, 12'h008, 32'hc, r, e);
    apb(1'b0, 12'h008, 32'h0, r, e);
    `CHK("events", 32'h0, r)
    clr();
    @(posedge clk);
    lmode <= 1'b1;
    boot();
    @(posedge clk);
    sat <= 1'b1;
    wsts(lps_pkg::ST_LATCH);
    `CHK("latched", 1'b1, lat)
    clr();
  endtask
  // Latched disable, generator cycling and mains release
  task automatic t_dis();
    boot();
    @(posedge clk);
    dis <= 1'b1;
    wsts(lps_pkg::ST_LATCH);
    `CHK("gate", 1'b0, gate)
    `CHK("low power", 1'b1, lp)
    @(posedge clk);
    dis <= 1'b0;
    vhy <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("hv", 1'b1, hv)
    `CHK("latched", 1'b1, lat)
    @(posedge clk);
    {vhy, von} <= 2'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("hv", 1'b0, hv)
    @(posedge clk);
    von <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("hv", 1'b0, hv)
    @(posedge clk);
    {vhy, mlo} <= 2'h3;
    wsts(lps_pkg::ST_RELEASE);
    `CHK("hv", 1'b0, hv)
    @(posedge clk);
    vrs <= 1'b1;
    wsts(lps_pkg::ST_OFF);
    @(posedge clk);
    {vhy, mlo, vrs} <= 3'h0;
  endtask
  // Overvoltage: window, consecutive count, latch and plain restart
  task automatic t_ovp();
    boot();
    @(posedge clk);
    {lvl, spk} <= 2'h3;
    repeat (400) @(posedge clk);
    wst(32'h7ff, 32'h004);
    @(posedge clk);
    spk <= 1'b0;
    wst(32'h7ff, 32'h304);
    @(posedge clk);
    lvl <= 1'b0;
    wst(32'h7ff, 32'h004);
    @(posedge clk);
    lvl <= 1'b1;
    wsts(lps_pkg::ST_OVP);
    `CHK("ff source", 1'b1, ffs)
    `CHK("gate", 1'b0, gate)
    wsts(lps_pkg::ST_LATCH);
    clr();
    @(posedge clk);
    lowz <= 1'b1;
    boot();
    @(posedge clk);
    lvl <= 1'b1;
    wsts(lps_pkg::ST_OVP);
    repeat (100) @(posedge clk);
    wsts(lps_pkg::ST_OVP);
    @(posedge clk);
    v5 <= 1'b1;
    wsts(lps_pkg::ST_OFF);
  endtask

  // Main sequence
  initial begin
    {rst_n, psel, pen, pwr, dis, uvlo, von, vhy, vrs, v5, mlo, sat, pwm} = 13'h0;
    {lmode, lvl, spk, lowz} = 4'h0;
    ce = 1'b1;
    pa = 12'h000;
    pwd = 32'h0;
    pc = 8'h00;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    t_regs();
    boot();
    t_ovl();
    t_dis();
    t_ovp();
    test_done();
  end
endmodule // tb_latched_protection_softstart_ovp
